// File: core/sbgt_pin_edge.sv
// Pin conditioning: two-stage synchroniser and edge detectors.
module sbgt_pin_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_sync_o,
  output logic fall_sync_o,
  output logic rise_async_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic raw_ff;

  // ==========================================================
  // Synchronised path; the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // ==========================================================
  // Unsynchronised path, two cycles sooner but with no settling.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_ff <= 1'b0;
    end else begin
      raw_ff <= pin_i;
    end
  end

  assign level_o = sync2_ff;
  assign rise_sync_o = sync2_ff & ~sync3_ff;
  assign fall_sync_o = ~sync2_ff & sync3_ff;
  assign rise_async_o = pin_i & ~raw_ff;

endmodule

// File: core/sbgt_pkg.sv
// Package of constants shared by the gated timer block.
package sbgt_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index.
  localparam logic [9:0] SBGT_IDX_COUNT = 10'h100;
  localparam logic [9:0] SBGT_IDX_PERIOD = 10'h102;
  localparam logic [9:0] SBGT_IDX_CTRL = 10'h104;
  localparam logic [9:0] SBGT_IDX_STATUS = 10'h106;
  localparam logic [9:0] SBGT_IDX_MASK = 10'h108;

  // ==========================================================
  // Control field positions.
  localparam int SBGT_CTL_EN = 15;
  localparam int SBGT_CTL_IDLE_STOP = 13;
  localparam int SBGT_CTL_GATE = 6;
  localparam int SBGT_CTL_PSEL_HI = 5;
  localparam int SBGT_CTL_PSEL_LO = 4;
  localparam int SBGT_CTL_SYNC = 2;
  localparam int SBGT_CTL_SRC = 1;
  localparam logic [15:0] SBGT_CTL_WMASK = 16'hA076;

  // ==========================================================
  // Status bits and reset values.
  localparam int SBGT_STS_MATCH = 0;
  localparam int SBGT_STS_GATE = 1;
  localparam logic [15:0] SBGT_RST_COUNT = 16'h0000;
  localparam logic [15:0] SBGT_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] SBGT_RST_CTRL = 16'h0000;
  localparam logic [1:0] SBGT_RST_STS = 2'h0;

  // ==========================================================
  // Prescaler terminal counts for divide by 1, 8, 64 and 256.
  localparam logic [7:0] SBGT_DIV1_LIM = 8'h00;
  localparam logic [7:0] SBGT_DIV8_LIM = 8'h07;
  localparam logic [7:0] SBGT_DIV64_LIM = 8'h3F;
  localparam logic [7:0] SBGT_DIV256_LIM = 8'hFF;

endpackage

// File: core/sbgt_prescaler.sv
// Four-step prescaler dividing an input tick stream.
module sbgt_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [1:0] psel_i,
  output logic tick_o
);
  import sbgt_pkg::*;

  logic [7:0] cnt_ff;
  logic [7:0] lim;

  always_comb begin
    case (psel_i)
      2'h0: lim = SBGT_DIV1_LIM;
      2'h1: lim = SBGT_DIV8_LIM;
      2'h2: lim = SBGT_DIV64_LIM;
      default: lim = SBGT_DIV256_LIM;
    endcase
  end

  assign tick_o = tick_i & (cnt_ff >= lim);

  // ==========================================================
  // Counter; a clear beats an arriving tick.
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_ff <= 8'h00;
    end else if (tick_o) begin
      cnt_ff <= 8'h00;
    end else if (tick_i) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  property p_pre_clear;
    @(posedge clk_i) disable iff (rst_i) clr_i |=> cnt_ff == 8'h00;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

  property p_pre_div8;
    @(posedge clk_i) disable iff (rst_i)
      (psel_i == 2'h1) && tick_i && !clr_i && (cnt_ff == 8'h06) |=> tick_i |-> tick_o;
  endproperty
  a_pre_div8: assert property (p_pre_div8) else $error("divide by 8 missed");

endmodule

// File: core/sbgt_timer.sv
// Top of the sixteen bit gated timer with its Wishbone register slave.
module sbgt_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_clock_gate_pin_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  output logic irq_o
);
  import sbgt_pkg::*;

  // ==========================================================
  // State.
  logic [15:0] count_register_ff;
  logic [15:0] period_value_ff;
  logic [15:0] timer_control_ff;
  logic [1:0] sts_ff;
  logic [1:0] mask_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  // ==========================================================
  // Decoded control fields.
  logic count_enable;
  logic idle_stop;
  logic gate_accumulate_enable;
  logic [1:0] prescale_select;
  logic external_sync_select;
  logic clock_source_select;

  assign count_enable = timer_control_ff[SBGT_CTL_EN];
  assign idle_stop = timer_control_ff[SBGT_CTL_IDLE_STOP];
  assign gate_accumulate_enable = timer_control_ff[SBGT_CTL_GATE];
  assign prescale_select = timer_control_ff[SBGT_CTL_PSEL_HI:SBGT_CTL_PSEL_LO];
  assign external_sync_select = timer_control_ff[SBGT_CTL_SYNC];
  assign clock_source_select = timer_control_ff[SBGT_CTL_SRC];

  // ==========================================================
  // Bus decode.
  logic req;
  logic wr_acc;
  logic [9:0] idx;
  logic hit_count;
  logic hit_period;
  logic hit_ctrl;
  logic hit_sts;
  logic hit_mask;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_sts;
  logic wr_mask;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_acc = req & wb_we_i & ack_ff;
  assign idx = wb_adr_i[11:2];
  assign hit_count = idx == SBGT_IDX_COUNT;
  assign hit_period = idx == SBGT_IDX_PERIOD;
  assign hit_ctrl = idx == SBGT_IDX_CTRL;
  assign hit_sts = idx == SBGT_IDX_STATUS;
  assign hit_mask = idx == SBGT_IDX_MASK;
  assign wr_count = wr_acc & hit_count;
  assign wr_period = wr_acc & hit_period;
  assign wr_ctrl = wr_acc & hit_ctrl;
  assign wr_sts = wr_acc & hit_sts;
  assign wr_mask = wr_acc & hit_mask;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  logic [15:0] nxt_ctrl;
  assign nxt_ctrl = merge(timer_control_ff, wb_dat_i, wb_sel_i) & SBGT_CTL_WMASK;

  // ==========================================================
  // Ack rises one cycle after the request and falls the next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  assign wb_ack_o = ack_ff;

  // ==========================================================
  // Read data, captured while the ack is being raised.
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_count) begin
      nxt_rdata[15:0] = count_register_ff;
    end else if (hit_period) begin
      nxt_rdata[15:0] = period_value_ff;
    end else if (hit_ctrl) begin
      nxt_rdata[15:0] = timer_control_ff;
    end else if (hit_sts) begin
      nxt_rdata[1:0] = sts_ff;
    end else if (hit_mask) begin
      nxt_rdata[1:0] = mask_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req && !ack_ff && !wb_we_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_dat_o = rdata_ff;

  // ==========================================================
  // Control and period registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_ff <= SBGT_RST_CTRL;
    end else if (wr_ctrl) begin
      timer_control_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_value_ff <= SBGT_RST_PERIOD;
    end else if (wr_period) begin
      period_value_ff <= merge(period_value_ff, wb_dat_i, wb_sel_i);
    end
  end

  // ==========================================================
  // Pin conditioning.
  logic gate_level;
  logic rise_sync;
  logic gate_fall;
  logic rise_async;

  sbgt_pin_edge u_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(external_clock_gate_pin_i),
    .level_o(gate_level),
    .rise_sync_o(rise_sync),
    .fall_sync_o(gate_fall),
    .rise_async_o(rise_async)
  );

  // ==========================================================
  // Tick selection and run qualification.
  logic async_mode;
  logic gated_mode;
  logic run;
  logic src_tick;
  logic pre_in;
  logic pre_clr;
  logic tick;

  assign async_mode = clock_source_select & ~external_sync_select;
  assign gated_mode = count_enable & gate_accumulate_enable & ~clock_source_select;
  // Only the asynchronous external counter keeps running through sleep.
  assign run = count_enable & ~(cpu_idle_i & idle_stop)
             & ~(cpu_sleep_i & ~async_mode);

  always_comb begin
    if (clock_source_select) begin
      src_tick = external_sync_select ? rise_sync : rise_async;
    end else if (gate_accumulate_enable) begin
      src_tick = gate_level;
    end else begin
      src_tick = 1'b1;
    end
  end

  assign pre_in = run & src_tick;
  assign pre_clr = wr_count | (wr_ctrl & ~nxt_ctrl[SBGT_CTL_EN]);

  sbgt_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(pre_clr),
    .tick_i(pre_in),
    .psel_i(prescale_select),
    .tick_o(tick)
  );

  // ==========================================================
  // Count register; a software write outranks a tick.
  logic match;
  assign match = tick & (count_register_ff == period_value_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_register_ff <= SBGT_RST_COUNT;
    end else if (wr_count) begin
      count_register_ff <= merge(count_register_ff, wb_dat_i, wb_sel_i);
    end else if (match) begin
      count_register_ff <= 16'h0000;
    end else if (tick) begin
      count_register_ff <= count_register_ff + 16'h0001;
    end
  end

  // ==========================================================
  // Sticky status, write one to clear; a new event beats the clear.
  logic [1:0] set_sts;
  logic [1:0] clr_sts;

  assign set_sts = {gated_mode & gate_fall, match};
  assign clr_sts = wr_sts && wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_ff <= SBGT_RST_STS;
    end else begin
      sts_ff <= (sts_ff & ~clr_sts) | set_sts;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= SBGT_RST_STS;
    end else if (wr_mask && wb_sel_i[0]) begin
      mask_ff <= wb_dat_i[1:0];
    end
  end

  assign irq_o = |(sts_ff & mask_ff);

  // ==========================================================
  // Assertions.
  property p_wrap;
    @(posedge clk_i) disable iff (rst_i) match && !wr_count |=> count_register_ff == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period");

  property p_inc;
    @(posedge clk_i) disable iff (rst_i)
      count_enable && !clock_source_select && !gate_accumulate_enable && !cpu_idle_i
      && !cpu_sleep_i && prescale_select == 2'h0 && !wr_count && !wr_ctrl
      && count_register_ff != period_value_ff
      |=> count_register_ff == $past(count_register_ff) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("count missed a cycle");

  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
      cpu_idle_i && idle_stop && !wr_count |=> $stable(count_register_ff);
  endproperty
  a_idle: assert property (p_idle) else $error("count moved in idle");

  property p_resume;
    @(posedge clk_i) disable iff (rst_i)
      $fell(cpu_idle_i) && count_enable && !clock_source_select && !gate_accumulate_enable
      && !cpu_sleep_i && prescale_select == 2'h0 && !wr_count
      |-> tick;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after idle");

  property p_sync_edge;
    @(posedge clk_i) disable iff (rst_i)
      run && clock_source_select && external_sync_select && prescale_select == 2'h0
      && rise_sync |-> tick;
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync edge not counted");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i) gated_mode && !gate_level |-> !pre_in;
  endproperty
  a_gate: assert property (p_gate) else $error("counted with gate low");

  property p_off;
    @(posedge clk_i) disable iff (rst_i) !count_enable && !wr_count |=> $stable(count_register_ff);
  endproperty
  a_off: assert property (p_off) else $error("count moved while off");

  property p_halt;
    @(posedge clk_i) disable iff (rst_i) !count_enable |-> !pre_in;
  endproperty
  a_halt: assert property (p_halt) else $error("prescaler fed while off");

  property p_ctrl_keep;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && !tick |=> $stable(count_register_ff);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved count");

  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
      cpu_sleep_i && !async_mode && !wr_count |=> $stable(count_register_ff);
  endproperty
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      match ##1 !(wr_sts && wb_sel_i[0] && wb_dat_i[0]) [*2] |-> sts_ff[SBGT_STS_MATCH];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("match flag lost");

  property p_gate_fall;
    @(posedge clk_i) disable iff (rst_i) gated_mode && gate_fall |=> sts_ff[SBGT_STS_GATE];
  endproperty
  a_gate_fall: assert property (p_gate_fall) else $error("gate fall not flagged");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  c_wrap: cover property (@(posedge clk_i) disable iff (rst_i) match);
  c_gate: cover property (@(posedge clk_i) disable iff (rst_i) gated_mode && gate_fall);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_async: cover property (@(posedge clk_i) disable iff (rst_i) async_mode && tick);

endmodule

// File: test/sbgt_pin_source.sv
// Model of the source that drives the external clock and gate pin.
module sbgt_pin_source (
  input wire logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pulse bursts.
  // The pin rests low between bursts, so no stray edge reaches the timer.
  initial pin_o = 1'b0;

  task automatic burst(input int p, input int h, input int l);
    repeat (p) begin
      pin_o <= 1'b1;
      repeat (h) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (l) @(posedge clk_i);
    end
  endtask
endmodule

// File: test/tb_sbgt_timer.sv
// Self-checking bench for the gated timer: bus tasks, scenario table, verdict.
module tb_sbgt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import sbgt_pkg::*;

  // ==========================================================
  // Stimulus and observed signals.
  localparam logic [11:0] A_CNT = {SBGT_IDX_COUNT, 2'h0};
  localparam logic [11:0] A_PER = {SBGT_IDX_PERIOD, 2'h0};
  localparam logic [11:0] A_CTL = {SBGT_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STS = {SBGT_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_MSK = {SBGT_IDX_MASK, 2'h0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pin;
  logic cpu_idle_i = 1'b0;
  logic cpu_sleep_i = 1'b0;
  logic irq_o;
  logic [31:0] rd;
  logic [3:0] sel_v = 4'h3;
  int error_cnt = 0;
  int samples_checked = 0;
  int test_no = 0;

  always #5 clk_i = ~clk_i;

  sbgt_timer sbgt_timer_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .external_clock_gate_pin_i(pin),
    .cpu_idle_i(cpu_idle_i),
    .cpu_sleep_i(cpu_sleep_i),
    .irq_o(irq_o)
  );

  sbgt_pin_source sbgt_pin_source_inst (
    .clk_i(clk_i),
    .pin_o(pin)
  );

  // ==========================================================
  // Reporting.
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t test %0d saw %h expected %h", $time, test_no, seen, exp);
    end
  endtask

  // ==========================================================
  // Bus access.
  // Entered just after a rising edge; returns one idle cycle after the ack.
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_v;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (i == 20) begin
      error_cnt++;
      final_report();
    end else begin
      @(posedge clk_i);
    end
  endtask

  task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    check(rd, exp);
  endtask

  // ==========================================================
  // One counting run.
  // The enable stands for 520 cycles: 517 waited plus the bus cycles that
  // lie between the two control writes. Idle held for k cycles blocks k+1.
  task automatic t(input logic [15:0] per, input logic [15:0] ctl, input int p,
      input int h, input int idle, input logic slp, input logic [15:0] cnt,
      input logic [1:0] sts);
    test_no++;
    cpu_idle_i <= (idle != 0);
    cpu_sleep_i <= slp;
    wb(1'b1, A_CTL, 32'h0000_0000);
    wb(1'b1, A_PER, {16'h0000, per});
    wb(1'b1, A_CNT, 32'h0000_0000);
    wb(1'b1, A_STS, 32'h0000_0003);
    wb(1'b1, A_CTL, {16'h0000, ctl});
    fork
      if (p > 0) sbgt_pin_source_inst.burst(p, h, 3);
      if (idle > 0 && idle < 517) begin
        repeat (idle) @(posedge clk_i);
        cpu_idle_i <= 1'b0;
      end
      repeat (517) @(posedge clk_i);
    join
    wb(1'b1, A_CTL, 32'h0000_0000);
    cpu_idle_i <= 1'b0;
    cpu_sleep_i <= 1'b0;
    rdchk(A_CNT, {16'h0000, cnt});
    rdchk(A_STS, {30'h0, sts});
    check({31'h0, irq_o}, {31'h0, |sts});
    wb(1'b1, A_STS, 32'h0000_0003);
    rdchk(A_STS, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0000_0000);
    $display("Test %0d done, mismatches so far %0d", test_no, error_cnt);
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(A_CNT, {16'h0000, SBGT_RST_COUNT});
    rdchk(A_PER, {16'h0000, SBGT_RST_PERIOD});
    rdchk(A_CTL, {16'h0000, SBGT_RST_CTRL});
    rdchk(A_STS, 32'h0000_0000);
    rdchk(A_MSK, 32'h0000_0000);
    wb(1'b1, A_CNT, 32'h0000_1234);
    wb(1'b1, A_CTL, 32'h0000_FFFF);
    rdchk(A_CTL, {16'h0000, SBGT_CTL_WMASK});
    rdchk(A_CNT, 32'h0000_1234);
    wb(1'b1, A_CTL, 32'h0000_0000);
    // Only the low byte lane is enabled, so the high byte must survive.
    sel_v = 4'h1;
    wb(1'b1, A_CNT, 32'h0000_FFAB);
    sel_v = 4'h3;
    rdchk(A_CNT, 32'h0000_12AB);
    wb(1'b1, 12'h7FC, 32'h0000_FFFF);
    rdchk(12'h7FC, 32'h0000_0000);
    wb(1'b1, A_MSK, 32'h0000_0003);
    rdchk(A_MSK, 32'h0000_0003);
    $display("Test 0 done, mismatches so far %0d", error_cnt);
    t(16'hFFFF, 16'h8000, 0, 0, 0, 1'b0, 16'h0208, 2'h0);
    t(16'hFFFF, 16'h8010, 0, 0, 0, 1'b0, 16'h0041, 2'h0);
    t(16'hFFFF, 16'h8020, 0, 0, 0, 1'b0, 16'h0008, 2'h0);
    t(16'hFFFF, 16'h8030, 0, 0, 0, 1'b0, 16'h0002, 2'h0);
    t(16'h0006, 16'h8000, 0, 0, 0, 1'b0, 16'h0002, 2'h1);
    t(16'hFFFF, 16'hA000, 0, 0, 9999, 1'b0, 16'h0000, 2'h0);
    t(16'hFFFF, 16'h8000, 0, 0, 9999, 1'b0, 16'h0208, 2'h0);
    t(16'hFFFF, 16'hA000, 0, 0, 100, 1'b0, 16'h01A3, 2'h0);
    t(16'hFFFF, 16'h8000, 0, 0, 0, 1'b1, 16'h0000, 2'h0);
    t(16'hFFFF, 16'h8006, 10, 3, 0, 1'b0, 16'h000A, 2'h0);
    t(16'hFFFF, 16'h8002, 10, 3, 0, 1'b0, 16'h000A, 2'h0);
    t(16'hFFFF, 16'hA002, 10, 3, 9999, 1'b0, 16'h0000, 2'h0);
    t(16'hFFFF, 16'h8002, 10, 3, 0, 1'b1, 16'h000A, 2'h0);
    t(16'hFFFF, 16'h8006, 10, 3, 0, 1'b1, 16'h0000, 2'h0);
    t(16'hFFFF, 16'h8040, 1, 40, 0, 1'b0, 16'h0028, 2'h2);
    t(16'hFFFF, 16'h8012, 16, 3, 0, 1'b0, 16'h0002, 2'h0);
    final_report();
  end
endmodule
